// ==== logic/dl_section_pkg.sv ====
// Constants and types shared by both ends of the download section link.
// Assumes a byte-serial link on one clock with synchronous reset.
package dl_section_pkg;

  localparam logic [7:0]  TABLE_ID_CANCEL = 8'h3B;
  localparam logic [7:0]  PROTO_DISC      = 8'h11;
  localparam logic [7:0]  MSG_TYPE_DL     = 8'h03;
  localparam logic [15:0] MSG_ID_CANCEL   = 16'h1005;
  localparam logic [1:0]  ORIG_SERVER     = 2'b10;
  localparam logic [1:0]  RSV2            = 2'b11;
  localparam logic [7:0]  RSV8            = 8'hFF;
  localparam logic [4:0]  CANCEL_VERSION  = 5'h00;
  localparam logic [7:0]  SECTION_NUM     = 8'h00;
  localparam logic [7:0]  STREAM_SYNC_DL  = 8'h14;
  localparam logic [31:0] CHECK_SYNC_DL   = 32'h00000000;
  localparam logic [11:0] SEC_LEN_MAX     = 12'hFFD;  // 4093
  localparam logic [15:0] PAYLOAD_MAX     = 16'h0FE2; // 4066
  localparam logic [15:0] BLOCK_FIX_BYTES = 16'h0006;
  // table_id_extension .. last_section_number, message header, check field
  localparam logic [16:0] EXT_FIX_BYTES   = 17'h00005;
  localparam logic [16:0] MSG_HDR_BYTES   = 17'h0000C;
  localparam logic [16:0] CHECK_BYTES     = 17'h00004;
  localparam logic [4:0]  CANCEL_HDR_LAST = 5'h13;    // 20 header bytes
  localparam logic [4:0]  BLOCK_HDR_LAST  = 5'h01;    // blockNumber only
  localparam logic [4:0]  CHECK_LAST      = 5'h03;
  localparam logic [4:0]  HDR_RESET       = 5'h00;
  localparam logic [15:0] CNT_RESET       = 16'h0000;

  typedef enum logic [1:0] {
    FR_IDLE  = 2'b00,
    FR_HEAD  = 2'b01,
    FR_BODY  = 2'b11,
    FR_CHECK = 2'b10
  } framer_state_e;

  typedef enum logic [1:0] {
    PA_WAIT = 2'b00,
    PA_HDR  = 2'b01,
    PA_SKIP = 2'b11
  } parser_state_e;

endpackage

// ==== logic/dl_section_if.sv ====
// Byte-serial section link between the framer and a parser or multiplexer.
// Both ends share ref_clk; the testbench instantiates and joins them.
`timescale 1ns/1ps
`default_nettype none
interface dl_section_if;
  logic       valid;
  logic [7:0] data;
  logic       sop;
  logic       eop;
  logic       ready;

  modport framer (output valid, output data, output sop, output eop, input ready);
  modport parser (input valid, input data, input sop, input eop, output ready);
endinterface
`default_nettype wire

// ==== logic/dl_section_framer.sv ====
// Section framer: emits a cancel-control section or the tail of a
// data-block section as a byte stream on the link.
// Assumes payload and link on ref_clk; check value computed upstream.
//
// Contract
// [RQ1] Cancel section opens with table_id 0x3B
// [RQ2] Syntax bit: 0 checksum, 1 CRC32
// [RQ3] private_indicator is inverse of syntax bit
// [RQ4] Section length from extension to check, max 4093
// [RQ5] Extension equals low transaction identifier bytes
// [RQ6] Cancel version_number is always zero
// [RQ7] Section and last section numbers zero
// [RQ8] Identification sub-field all zeros
// [RQ9] Originator sub-field carries 10b
// [RQ10] Block number counts from zero
// [RQ11] Payload bytes: length minus adaptation minus six
// [RQ12] Synchronized download blocks: syntax 0, zero check
// [RQ13] messageLength excludes the trailing check field
// [RQ14] Updated bit toggles on each content change
// [RQ15] Fixed header constants, current set, reserved ones
// [RQ16] Parser discards cancel sections with bad constants
`timescale 1ns/1ps
`default_nettype none
module dl_section_framer (
  input  wire logic          ref_clk,      // 20 MHz clock
  input  wire logic          rst,          // Sync reset, active high
  dl_section_if.framer       lnk,          // Section byte stream out
  input  wire logic          start,        // Pulse: begin a section
  input  wire logic          kind_block,   // 1 data-block tail, 0 cancel
  input  wire logic [7:0]    stream_type,  // Stream type of the block
  input  wire logic          syntax_crc,   // Check field is a CRC32
  input  wire logic          changed,      // Cancel content differs
  input  wire logic [13:0]   version_sub,  // Transaction version
  input  wire logic [7:0]    adapt_len,    // adaptationLength
  input  wire logic [15:0]   msg_len,      // messageLength
  input  wire logic [15:0]   block_num,    // Block index in module
  input  wire logic [31:0]   check_val,    // Checksum or CRC32
  input  wire logic          pay_valid,    // Payload byte offered
  input  wire logic [7:0]    pay_data,     // Payload byte
  output logic               pay_ready,    // Payload byte taken
  output logic               busy,         // Section in progress
  output logic               err           // Pulse: start refused
);
  import dl_section_pkg::*;

  typedef struct packed {
    framer_state_e state;
    logic [4:0]    idx;
    logic [15:0]   cnt;
    logic          vld;
    logic [7:0]    data;
    logic          sop;
    logic          eop;
    logic          updated;
    logic          syn;
    logic          kind;
    logic [13:0]   ver;
    logic [7:0]    adapt;
    logic [15:0]   mlen;
    logic [15:0]   blk;
    logic [11:0]   slen;
    logic [31:0]   chk;
    logic          err;
  } framer_s;

  framer_s cur;
  framer_s next_cur;

  logic        load;
  logic [16:0] sec_len_full;
  logic [15:0] block_pay;
  logic        block_sync;

  function automatic logic [7:0] hdr_byte(input framer_s s);
    logic [31:0] tid;
    logic [7:0]  b;
    tid = {ORIG_SERVER, s.ver, 15'h0000, s.updated};  // see [RQ8] see [RQ9]
    b = 8'h00;
    if (s.kind) begin
      b = (s.idx == HDR_RESET) ? s.blk[15:8] : s.blk[7:0];  // see [RQ10]
    end else begin
      unique case (s.idx)
        5'h00: b = TABLE_ID_CANCEL;  // see [RQ1]
        5'h01: b = {s.syn, ~s.syn, RSV2, s.slen[11:8]};  // see [RQ2] see [RQ3]
        5'h02: b = s.slen[7:0];  // see [RQ4]
        5'h03: b = tid[15:8];  // see [RQ5]
        5'h04: b = tid[7:0];
        5'h05: b = {RSV2, CANCEL_VERSION, 1'b1};  // see [RQ6] see [RQ15]
        5'h06: b = SECTION_NUM;  // see [RQ7]
        5'h07: b = SECTION_NUM;
        5'h08: b = PROTO_DISC;  // see [RQ15]
        5'h09: b = MSG_TYPE_DL;
        5'h0A: b = MSG_ID_CANCEL[15:8];
        5'h0B: b = MSG_ID_CANCEL[7:0];
        5'h0C: b = tid[31:24];
        5'h0D: b = tid[23:16];
        5'h0E: b = tid[15:8];
        5'h0F: b = tid[7:0];
        5'h10: b = RSV8;
        5'h11: b = s.adapt;
        5'h12: b = s.mlen[15:8];  // see [RQ13]
        default: b = s.mlen[7:0];
      endcase
    end
    return b;
  endfunction

  // Length counts extension fields, message header, body and check
  assign sec_len_full = EXT_FIX_BYTES + MSG_HDR_BYTES + {1'b0, msg_len} + CHECK_BYTES;
  assign block_pay    = msg_len - {8'h00, adapt_len} - BLOCK_FIX_BYTES;  // see [RQ11]
  assign block_sync   = (stream_type == STREAM_SYNC_DL);
  assign load         = !cur.vld || lnk.ready;

  always_comb begin
    next_cur     = cur;
    next_cur.err = 1'b0;
    pay_ready    = 1'b0;
    if (cur.vld && lnk.ready) begin
      next_cur.vld = 1'b0;
      next_cur.sop = 1'b0;
      next_cur.eop = 1'b0;
    end
    unique case (cur.state)
      FR_IDLE: begin
        if (start) begin
          // Refuse lengths the 12-bit field or payload limit cannot hold
          if (kind_block ? ({8'h00, adapt_len} + BLOCK_FIX_BYTES > msg_len
                            || block_pay > PAYLOAD_MAX)
                         : (sec_len_full > {5'h00, SEC_LEN_MAX})) begin  // see [RQ4]
            next_cur.err = 1'b1;
          end else begin
            next_cur.state = FR_HEAD;
            next_cur.idx   = HDR_RESET;
            next_cur.kind  = kind_block;
            next_cur.ver   = version_sub;
            next_cur.adapt = adapt_len;
            next_cur.mlen  = msg_len;
            next_cur.blk   = block_num;
            next_cur.slen  = sec_len_full[11:0];
            next_cur.cnt   = kind_block ? block_pay : msg_len;
            if (kind_block && block_sync) begin
              next_cur.syn = 1'b0;  // see [RQ12]
              next_cur.chk = CHECK_SYNC_DL;
            end else begin
              next_cur.syn = syntax_crc;  // see [RQ2]
              next_cur.chk = check_val;
            end
            if (!kind_block && changed) begin
              next_cur.updated = ~cur.updated;  // see [RQ14]
            end
          end
        end
      end
      FR_HEAD: begin
        if (load) begin
          next_cur.vld  = 1'b1;
          next_cur.data = hdr_byte(cur);
          next_cur.sop  = (cur.idx == HDR_RESET) && !cur.kind;
          next_cur.idx  = cur.idx + 5'h01;
          if (cur.idx == (cur.kind ? BLOCK_HDR_LAST : CANCEL_HDR_LAST)) begin
            next_cur.idx   = HDR_RESET;
            next_cur.state = (cur.cnt == CNT_RESET) ? FR_CHECK : FR_BODY;
          end
        end
      end
      FR_BODY: begin
        pay_ready = load;
        if (load && pay_valid) begin
          next_cur.vld  = 1'b1;
          next_cur.data = pay_data;
          next_cur.cnt  = cur.cnt - 16'h0001;  // see [RQ11]
          if (cur.cnt == 16'h0001) begin
            next_cur.state = FR_CHECK;
          end
        end
      end
      FR_CHECK: begin
        if (load) begin
          next_cur.vld  = 1'b1;
          next_cur.data = cur.chk[31:24];
          next_cur.chk  = {cur.chk[23:0], 8'h00};
          next_cur.idx  = cur.idx + 5'h01;
          if (cur.idx == CHECK_LAST) begin
            next_cur.eop   = 1'b1;
            next_cur.idx   = HDR_RESET;
            next_cur.state = FR_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign lnk.valid = cur.vld;
  assign lnk.data  = cur.data;
  assign lnk.sop   = cur.sop;
  assign lnk.eop   = cur.eop;
  assign busy      = (cur.state != FR_IDLE);
  assign err       = cur.err;
endmodule
`default_nettype wire

// ==== logic/dl_section_parser.sv ====
// Receiver-side parser: checks the cancel section header on the link
// and reports its fields; other sections and body bytes pass unused.
// Assumes the framer end on the same ref_clk.
`timescale 1ns/1ps
`default_nettype none
module dl_section_parser (
  input  wire logic          ref_clk,      // 20 MHz clock
  input  wire logic          rst,          // Sync reset, active high
  dl_section_if.parser       lnk,          // Section byte stream in
  output logic               hdr_ok,       // Pulse: cancel header valid
  output logic               hdr_bad,      // Pulse: cancel discarded
  output logic               syntax_crc,   // Check field is a CRC32
  output logic               updated,      // Updated sub-field
  output logic [13:0]        version_sub,  // Transaction version
  output logic [15:0]        msg_len       // messageLength
);
  import dl_section_pkg::*;

  typedef struct packed {
    parser_state_e state;
    logic [4:0]    idx;
    logic          bad;
    logic [11:0]   slen;
    logic [15:0]   ext;
    logic          syn;
    logic          upd;
    logic [13:0]   ver;
    logic [15:0]   mlen;
    logic          ok;
    logic          nok;
  } parser_s;

  parser_s cur;
  parser_s next_cur;

  logic        take;
  logic        mism;
  logic [7:0]  d;
  logic [16:0] want_len;

  assign take     = lnk.valid;
  assign d        = lnk.data;
  assign want_len = EXT_FIX_BYTES + MSG_HDR_BYTES + {1'b0, cur.mlen[15:8], d} + CHECK_BYTES;

  // Byte-by-byte comparison against the fixed cancel layout
  always_comb begin
    mism = 1'b0;
    unique case (cur.idx)
      5'h01: mism = (d[6] == d[7]) || (d[5:4] != RSV2);
      5'h05: mism = (d != {RSV2, CANCEL_VERSION, 1'b1});
      5'h06: mism = (d != SECTION_NUM);
      5'h07: mism = (d != SECTION_NUM);
      5'h08: mism = (d != PROTO_DISC);
      5'h09: mism = (d != MSG_TYPE_DL);
      5'h0A: mism = (d != MSG_ID_CANCEL[15:8]);
      5'h0B: mism = (d != MSG_ID_CANCEL[7:0]);
      5'h0C: mism = (d[7:6] != ORIG_SERVER);
      5'h0E: mism = (d != 8'h00) || (d != cur.ext[15:8]);
      5'h0F: mism = (d[7:1] != 7'h00) || (d != cur.ext[7:0]);
      5'h10: mism = (d != RSV8);
      5'h13: mism = (want_len[11:0] != cur.slen) || want_len[16:12] != 5'h00;
      default: mism = 1'b0;
    endcase
  end

  always_comb begin
    next_cur     = cur;
    next_cur.ok  = 1'b0;
    next_cur.nok = 1'b0;
    unique case (cur.state)
      PA_WAIT: begin
        if (take && lnk.sop) begin
          next_cur.idx   = 5'h01;
          next_cur.bad   = 1'b0;
          next_cur.state = (d == TABLE_ID_CANCEL) ? PA_HDR : PA_SKIP;
          if (lnk.eop) begin
            next_cur.state = PA_WAIT;
            next_cur.nok   = (d == TABLE_ID_CANCEL);
          end
        end
      end
      PA_HDR: begin
        if (take) begin
          next_cur.idx = cur.idx + 5'h01;
          next_cur.bad = cur.bad | mism;
          unique case (cur.idx)
            5'h01: begin
              next_cur.syn        = d[7];
              next_cur.slen[11:8] = d[3:0];
            end
            5'h02: next_cur.slen[7:0] = d;
            5'h03: next_cur.ext[15:8] = d;
            5'h04: next_cur.ext[7:0]  = d;
            5'h0C: next_cur.ver[13:8] = d[5:0];
            5'h0D: next_cur.ver[7:0]  = d;
            5'h0F: next_cur.upd       = d[0];
            5'h12: next_cur.mlen[15:8] = d;
            5'h13: next_cur.mlen[7:0]  = d;
            default: next_cur.idx = cur.idx + 5'h01;
          endcase
          // Discard rather than act on a wrong or short header
          if (cur.idx == CANCEL_HDR_LAST) begin
            next_cur.ok    = !(cur.bad | mism);  // see [RQ16]
            next_cur.nok   = cur.bad | mism;
            next_cur.state = lnk.eop ? PA_WAIT : PA_SKIP;
          end else if (lnk.eop) begin
            next_cur.nok   = 1'b1;
            next_cur.state = PA_WAIT;
          end
        end
      end
      PA_SKIP: begin
        if (take && lnk.eop) begin
          next_cur.state = PA_WAIT;
        end
      end
      default: next_cur.state = PA_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign lnk.ready   = 1'b1;
  assign hdr_ok      = cur.ok;
  assign hdr_bad     = cur.nok;
  assign syntax_crc  = cur.syn;
  assign updated     = cur.upd;
  assign version_sub = cur.ver;
  assign msg_len     = cur.mlen;
endmodule
`default_nettype wire

// ==== verif/dl_section_link_asserts.sv ====
// Cancel section header checks on the framer to parser link.
// Assumes the parser holds ready high, so header bytes follow sop back to back.
`timescale 1ns/1ps
`default_nettype none
module dl_section_link_asserts (
  input wire logic       ref_clk, // Link clock
  input wire logic       rst,     // Sync reset
  input wire logic       valid,   // Byte present
  input wire logic [7:0] data,    // Section byte
  input wire logic       sop,     // First cancel byte
  input wire logic       eop,     // Last check byte
  input wire logic       ready    // Byte taken
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_sop;
    valid && ready && sop;
  endsequence
  sequence s_msg;
    data == 8'h11 ##1 data == 8'h03 ##1 data == 8'h10 ##1 data == 8'h05;
  endsequence
  property p_tid; s_sop |-> data == 8'h3B && !eop; endproperty
  a_tid: assert property (p_tid) else $error("table id wrong");
  property p_pi; s_sop |=> valid && data[6] == !data[7] && data[5:4] == 2'b11; endproperty
  a_pi: assert property (p_pi) else $error("private bit wrong");
  property p_lmax; s_sop |-> ##2 ({$past(data), data} & 16'h0FFF) <= 16'h0FFD; endproperty
  a_lmax: assert property (p_lmax) else $error("length over limit");
  property p_len;
    s_sop |-> ##19 ({$past(data, 18), $past(data, 17)} & 16'h0FFF)
                   == {$past(data), data} + 16'h0015;
  endproperty
  a_len: assert property (p_len) else $error("length mismatch");
  property p_ext;
    s_sop |-> ##3 data == 8'h00 ##1 data[7:1] == 7'h00 ##11 data[0] == $past(data[0], 11);
  endproperty
  a_ext: assert property (p_ext) else $error("extension mismatch");
  property p_ver; s_sop |-> ##5 data == 8'hC1; endproperty
  a_ver: assert property (p_ver) else $error("version byte wrong");
  property p_sec; s_sop |-> ##6 data == 8'h00 ##1 data == 8'h00; endproperty
  a_sec: assert property (p_sec) else $error("section number wrong");
  property p_orig; s_sop |-> ##12 data[7:6] == 2'b10; endproperty
  a_orig: assert property (p_orig) else $error("originator wrong");
  property p_ident; s_sop |-> ##14 data == 8'h00 ##1 data[7:1] == 7'h00; endproperty
  a_ident: assert property (p_ident) else $error("identification wrong");
  property p_hdr; s_sop |-> ##8 s_msg ##5 data == 8'hFF; endproperty
  a_hdr: assert property (p_hdr) else $error("message header wrong");
endmodule
`default_nettype wire

// ==== verif/download_section_framer_tb.sv ====
// Framer and parser joined on one link; a second parser is fed damaged headers.
// Assumes both ends on ref_clk, parser ready tied high.
`timescale 1ns/1ps
`default_nettype none
module download_section_framer_tb;
  import dl_section_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, start = 1'b0, kind_block = 1'b0, syntax_crc = 1'b0;
  logic changed = 1'b0, pay_valid = 1'b0, pay_ready, busy, err, hdr_ok, hdr_bad, ok2, bad2;
  logic [7:0] stream_type = 8'h00, adapt_len = 8'h00, pay_data = 8'h00;
  logic [13:0] version_sub = 14'h0000, p_ver;
  logic [15:0] msg_len = 16'h0000, block_num = 16'h0000, p_len;
  logic [31:0] check_val = 32'h00000000;
  logic p_ssi, p_upd, upd_m = 1'b0, exp_ssi, exp_upd;
  logic [13:0] exp_ver;
  logic [15:0] exp_len;
  logic [9:0] exp_q[$];
  logic [7:0] pay_q[$], hb[20];
  int fails = 0, checks_done = 0, pidx = 0, ok_n = 0, ok_exp = 0, bad2_n = 0, k;
  int cidx[8] = '{1, 2, 3, 5, 6, 7, 8, 10};
  logic [7:0] cmsk[8] = '{8'h40, 8'h01, 8'h01, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01};
  dl_section_if lnk ();
  dl_section_if lnk2 ();
  dl_section_framer u_dl_section_framer (.ref_clk(ref_clk), .rst(rst), .lnk(lnk),
    .start(start), .kind_block(kind_block), .stream_type(stream_type), .syntax_crc(syntax_crc),
    .changed(changed), .version_sub(version_sub), .adapt_len(adapt_len), .msg_len(msg_len),
    .block_num(block_num), .check_val(check_val), .pay_valid(pay_valid), .pay_data(pay_data),
    .pay_ready(pay_ready), .busy(busy), .err(err));
  dl_section_parser u_dl_section_parser (.ref_clk(ref_clk), .rst(rst), .lnk(lnk),
    .hdr_ok(hdr_ok), .hdr_bad(hdr_bad), .syntax_crc(p_ssi), .updated(p_upd),
    .version_sub(p_ver), .msg_len(p_len));
  dl_section_parser u_dl_section_parser_b (.ref_clk(ref_clk), .rst(rst), .lnk(lnk2),
    .hdr_ok(ok2), .hdr_bad(bad2), .syntax_crc(), .updated(), .version_sub(), .msg_len());
  dl_section_link_asserts u_dl_section_link_asserts (.ref_clk(ref_clk), .rst(rst),
    .valid(lnk.valid), .data(lnk.data), .sop(lnk.sop), .eop(lnk.eop), .ready(lnk.ready));
  always #25 ref_clk = ~ref_clk;
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp_link(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected link byte at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge ref_clk) begin
    if (lnk.valid === 1'b1 && lnk.ready === 1'b1) begin
      if (exp_q.size() == 0) cmp_link({lnk.sop, lnk.eop, lnk.data}, 10'h3FF);
      else cmp_link({lnk.sop, lnk.eop, lnk.data}, exp_q.pop_front());
    end
    if (hdr_ok === 1'b1) begin
      ok_n++;
      cmp_val({p_ssi, p_upd, p_ver, p_len}, {exp_ssi, exp_upd, exp_ver, exp_len});
    end
    // Parser state is unknown until the first reset edge has passed
    if (!rst && hdr_bad !== 1'b0) cmp_val({31'h0, hdr_bad}, 32'h0);
    if (!rst && ok2 !== 1'b0) cmp_val({31'h0, ok2}, 32'h0);
    if (bad2 === 1'b1) bad2_n++;
  end
  // Payload source stalls at random; the link side never refuses
  always @(posedge ref_clk) begin
    if (pay_valid && pay_ready) pidx++;
    pay_valid <= (pidx < pay_q.size()) && ($urandom_range(3) != 0);
    pay_data <= (pidx < pay_q.size()) ? pay_q[pidx] : 8'h00;
  end
  task automatic mk_hdr(input logic s, input logic u, input logic [13:0] v,
                        input logic [7:0] a, input logic [15:0] ml);
    logic [15:0] l;
    l = ml + 16'h0015;
    hb = '{8'h3B, {s, ~s, 2'b11, l[11:8]}, l[7:0], 8'h00, {7'h00, u}, 8'hC1, 8'h00, 8'h00,
           8'h11, 8'h03, 8'h10, 8'h05, {2'b10, v[13:8]}, v[7:0], 8'h00, {7'h00, u}, 8'hFF,
           a, ml[15:8], ml[7:0]};
  endtask
  task automatic run(input logic kb, input logic [7:0] st, input logic [7:0] a,
                     input logic [15:0] ml, input logic ch);
    logic [15:0] n, bn;
    logic [31:0] cv;
    logic [13:0] v;
    logic s, refuse;
    int i;
    n = kb ? ml - {8'h00, a} - 16'h0006 : ml;
    refuse = kb ? ({8'h00, a} + 16'h0006 > ml || n > 16'h0FE2) : (ml + 16'h0015 > 16'h0FFD);
    cv = $urandom();
    v = 14'($urandom());
    bn = 16'($urandom());
    s = 1'($urandom());
    @(posedge ref_clk);
    pay_q.delete();
    pidx = 0;
    kind_block <= kb;
    stream_type <= st;
    adapt_len <= a;
    msg_len <= ml;
    syntax_crc <= s;
    changed <= ch;
    version_sub <= v;
    block_num <= bn;
    check_val <= cv;
    start <= 1'b1;
    if (!refuse) begin
      for (i = 0; i < n; i++) pay_q.push_back(8'($urandom()));
      if (kb) begin
        exp_q.push_back({2'b00, bn[15:8]});
        exp_q.push_back({2'b00, bn[7:0]});
        if (st == 8'h14) cv = 32'h00000000;
      end else begin
        upd_m = upd_m ^ ch;
        mk_hdr(s, upd_m, v, a, ml);
        foreach (hb[j]) exp_q.push_back({j == 0, 1'b0, hb[j]});
        {exp_ssi, exp_upd, exp_ver, exp_len} = {s, upd_m, v, ml};
        ok_exp++;
      end
      foreach (pay_q[j]) exp_q.push_back({2'b00, pay_q[j]});
      for (i = 3; i >= 0; i--) exp_q.push_back({1'b0, i == 0, cv[8 * i +: 8]});
    end
    @(posedge ref_clk);
    start <= 1'b0;
    @(negedge ref_clk);
    cmp_val({busy, err}, {~refuse, refuse});
    for (i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge ref_clk);
    if (i == 20000) begin
      fails++;
      conclude;
    end
    repeat (3) @(posedge ref_clk);
    cmp_val(exp_q.size(), 32'h0);
  endtask
  task automatic raw(input int idx, input logic [7:0] m);
    int i, b;
    b = bad2_n;
    mk_hdr(1'b1, 1'b0, 14'h0155, 8'h00, 16'h0000);
    hb[idx] = hb[idx] ^ m;
    for (i = 0; i < 24; i++) begin
      @(posedge ref_clk);
      lnk2.valid <= 1'b1;
      lnk2.sop <= (i == 0);
      lnk2.eop <= (i == 23);
      lnk2.data <= (i < 20) ? hb[i] : 8'h00;
    end
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      lnk2.valid <= 1'b0;
      lnk2.eop <= 1'b0;
      lnk2.data <= ~lnk2.data;
    end
    cmp_val(bad2_n - b, 32'h1);
  endtask
  initial begin
    {lnk2.valid, lnk2.sop, lnk2.eop, lnk2.data} <= 11'h000;
    void'($urandom(32'h76e0));
    repeat (3) @(posedge ref_clk);
    cmp_val({busy, err, pay_ready, lnk.valid, hdr_ok}, 32'h0);
    rst <= 1'b0;
    run(1'b0, 8'h00, 8'h00, 16'h0000, 1'b1);
    for (k = 0; k < 6; k++) run(1'b0, 8'h00, 8'(k), 16'($urandom_range(12)), 1'(k));
    run(1'b0, 8'h00, 8'h00, 16'h0FE8, 1'b0);
    run(1'b0, 8'h00, 8'h00, 16'h0FE9, 1'b1);
    run(1'b0, 8'h00, 8'h01, 16'h0003, 1'b0);
    for (k = 0; k < 4; k++)
      run(1'b1, k[0] ? 8'h14 : 8'h0B, 8'(k), 16'(k + 6 + $urandom_range(9)), 1'b0);
    run(1'b1, 8'h14, 8'h02, 16'h0007, 1'b0);
    run(1'b1, 8'h0B, 8'h00, 16'h0006, 1'b0);
    run(1'b1, 8'h0B, 8'h00, 16'h0FE9, 1'b0);
    run(1'b1, 8'h14, 8'h00, 16'h0FE8, 1'b0);
    for (k = 0; k < 8; k++) raw(cidx[k], cmsk[k]);
    cmp_val(ok_n, ok_exp);
    conclude;
  end
endmodule
`default_nettype wire
